// [asp_pkg.sv]
// Package of constants for the async serial port pin block
package asp_pkg;
  // Register byte offsets
  localparam logic [3:0] ASP_CTRL_OFF = 4'h0;
  localparam logic [3:0] ASP_STAT_OFF = 4'h4;
  localparam logic [3:0] ASP_TXD_OFF = 4'h8;
  localparam logic [3:0] ASP_RXD_OFF = 4'hC;
  // Control field positions
  localparam int ASP_CTRL_TXEN = 0;
  localparam int ASP_CTRL_RXEN = 1;
  localparam int ASP_CTRL_LOOP = 2;
  localparam int ASP_CTRL_AUTOCTS = 3;
  localparam int ASP_CTRL_AUTORTS = 4;
  localparam int ASP_CTRL_RTSMAN = 5;
  localparam int ASP_CTRL_CLKSTOP = 6;
  localparam int ASP_CTRL_W = 7;
  // Status field positions
  localparam int ASP_STAT_TXRDY = 0;
  localparam int ASP_STAT_RXAV = 1;
  localparam int ASP_STAT_TXBUSY = 2;
  localparam int ASP_STAT_CTS = 3;
  localparam int ASP_STAT_RTS = 4;
  localparam int ASP_STAT_CLKRUN = 5;
  localparam int ASP_STAT_FRERR = 6;
  localparam int ASP_STAT_OVR = 7;
  // Reset values
  localparam logic [6:0] ASP_CTRL_RST = 7'h00;
  localparam logic [15:0] ASP_DIV_RST = 16'h0036;
  // Timing: default baud and the derived divider
  localparam int ASP_CLK_HZ = 100_000_000;
  localparam int ASP_BAUD = 115_200;
  localparam int ASP_OVS = 16;
  localparam int ASP_DIV_CYC = ASP_CLK_HZ / (ASP_BAUD * ASP_OVS);
  localparam int ASP_DATA_W = 8;
  localparam int ASP_RXQ_DEPTH = 2;
endpackage : asp_pkg

// [asp_stream_if.sv]
// Byte stream interface between the port modules
`timescale 1ns/1ps
interface asp_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : asp_stream_if

// [asp_rx_queue.sv]
// Two-entry receive queue with valid and ready on both sides
`timescale 1ns/1ps
module asp_rx_queue
  import asp_pkg::*;
#(
  parameter int W = ASP_DATA_W
)(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Sync reset
  asp_stream_if.snk in_s, // Fill side
  asp_stream_if.src out_s, // Drain side
  output logic [1:0] level_o // Entries held
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic [1:0] cnt;
  } asp_q_type;
  asp_q_type st_ff;
  asp_q_type nxt_st;
  logic push;
  logic pop;
  // Handshakes
  assign in_s.ready = (st_ff.cnt != 2'd2);
  assign out_s.valid = (st_ff.cnt != 2'd0);
  assign out_s.data = st_ff.mem[0];
  assign level_o = st_ff.cnt;
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;
  // Shift-style storage, head at entry zero
  always_comb
  begin
    nxt_st = st_ff;
    if (pop)
    begin
      nxt_st.mem[0] = st_ff.mem[1];
    end
    if (push)
    begin
      if (pop)
        nxt_st.mem[st_ff.cnt - 2'd1] = in_s.data;
      else
        nxt_st.mem[st_ff.cnt[0]] = in_s.data;
    end
    nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
  end
  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
endmodule : asp_rx_queue

// [asp_rx_frame.sv]
// Receive deframer, LSB first, sampled mid-bit
`timescale 1ns/1ps
module asp_rx_frame
  import asp_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Sync reset
  input wire logic tick_i, // Oversample enable
  input wire logic en_i, // Receiver enable
  input wire logic rx_i, // Serial input
  asp_stream_if.src out_s, // Received bytes
  output logic frerr_o // Stop bit low, pulse
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asp_rxs_type;
  typedef struct packed {
    asp_rxs_type fsm;
    logic [3:0] ph;
    logic [2:0] bitn;
    logic [ASP_DATA_W-1:0] sh;
    logic vld;
    logic ferr;
  } asp_rx_type;
  asp_rx_type st_ff;
  asp_rx_type nxt_st;
  assign out_s.valid = st_ff.vld;
  assign out_s.data = st_ff.sh;
  assign frerr_o = st_ff.ferr;
  // Frame sequencer
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.ferr = 1'b0;
    if (out_s.ready)
      nxt_st.vld = 1'b0;
    if (tick_i && en_i)
    begin
      nxt_st.ph = st_ff.ph + 4'd1;
      unique case (st_ff.fsm)
        RX_IDLE:
        begin
          nxt_st.ph = 4'd0;
          // Hold off a new frame while the last byte is still unclaimed
          if (!rx_i && !st_ff.vld)
            nxt_st.fsm = RX_START;
        end
        RX_START:
          if (st_ff.ph == 4'd7)
          begin
            nxt_st.ph = 4'd0;
            nxt_st.fsm = rx_i ? RX_IDLE : RX_DATA;
            nxt_st.bitn = 3'd0;
          end
        RX_DATA:
          if (st_ff.ph == 4'd15)
          begin
            nxt_st.sh = {rx_i, st_ff.sh[ASP_DATA_W-1:1]};
            nxt_st.bitn = st_ff.bitn + 3'd1;
            if (st_ff.bitn == 3'd7)
              nxt_st.fsm = RX_STOP;
          end
        RX_STOP:
          if (st_ff.ph == 4'd15)
          begin
            nxt_st.fsm = RX_IDLE;
            if (rx_i)
              nxt_st.vld = 1'b1;
            else
              nxt_st.ferr = 1'b1;
          end
      endcase
    end
    if (!en_i)
      nxt_st.fsm = RX_IDLE;
  end
  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_ff <= '{fsm: RX_IDLE, default: '0};
    else
      st_ff <= nxt_st;
  end
endmodule : asp_rx_frame

// [asp_top.sv]
// Async serial port pin logic with Wishbone register access
//
// Overview of operation
// - Transmit line high when disabled, idle, looped
// - Transmit LSB first, change on falling tick
// - Receive bits assembled LSB first
// - Any receive-line transition restarts stopped clock
// - Clear-to-send asserted permits starting transmission
// - Request-to-send driven by hardware, or by the manual RTSMAN bit
// - Request-to-send follows receive queue fill level
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module asp_top
  import asp_pkg::*;
#(
  parameter logic [15:0] DIV_CYC = 16'(ASP_DIV_CYC)
)(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Sync reset, active high
  input wire logic [3:0] wb_adr_i, // Byte address
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  input wire logic wb_we_i, // Write enable
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_cyc_i, // Cycle
  output logic wb_ack_o, // Acknowledge
  output logic serial_tx_out_o, // Serial data out
  input wire logic serial_rx_in_i, // Serial data in
  input wire logic clear_to_send_in_n_i, // Permit to send, low active
  output logic request_to_send_out_n_o // Ready to receive, low active
);
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} asp_txs_type;
  typedef struct packed {
    logic [ASP_CTRL_W-1:0] ctrl;
    logic [15:0] div_cnt;
    logic [3:0] fall_cnt;
    logic clk_run;
    logic rx_prev;
    asp_txs_type tx_fsm;
    logic [2:0] tx_bit;
    logic [ASP_DATA_W-1:0] tx_sh;
    logic [ASP_DATA_W-1:0] tx_hold;
    logic tx_full;
    logic tx_line;
    logic rts_n;
    logic frerr;
    logic ovr;
    logic ack;
    logic [31:0] rdat;
  } asp_top_type;
  asp_top_type st_ff;
  asp_top_type nxt_st;
  logic tick;
  logic bit_fall;
  logic cts;
  logic loop_rx;
  logic rx_frerr;
  logic [1:0] q_level;
  logic req;
  logic [ASP_DATA_W-1:0] rxd_pop;
  asp_stream_if #(.W(ASP_DATA_W)) fr_s ();
  asp_stream_if #(.W(ASP_DATA_W)) q_s ();

  // Receive path: deframer feeds the two-entry queue
  assign loop_rx = st_ff.ctrl[ASP_CTRL_LOOP] ? st_ff.tx_line : serial_rx_in_i;
  asp_rx_frame u_rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .en_i(st_ff.ctrl[ASP_CTRL_RXEN]),
    .rx_i(loop_rx),
    .out_s(fr_s.src),
    .frerr_o(rx_frerr)
  );
  asp_rx_queue #(.W(ASP_DATA_W)) u_q (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_s(fr_s.snk),
    .out_s(q_s.src),
    .level_o(q_level)
  );

  // Oversample tick, gated by the port clock run state
  assign tick = st_ff.clk_run && (st_ff.div_cnt == 16'd0);
  // Bit boundary is the falling edge of the bit clock
  assign bit_fall = tick && (st_ff.fall_cnt == 4'd15);
  assign cts = !clear_to_send_in_n_i;
  assign req = wb_cyc_i && wb_stb_i && !st_ff.ack;
  assign q_s.ready = req && !wb_we_i && (wb_adr_i == ASP_RXD_OFF);
  assign rxd_pop = q_s.valid ? q_s.data : '0;

  // Outputs from flip-flops
  assign serial_tx_out_o = st_ff.tx_line;
  assign request_to_send_out_n_o = st_ff.rts_n;
  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = st_ff.rdat;

  // Next-state logic for bus, clocking, transmitter and handshakes
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.ack = req;
    nxt_st.rdat = '0;
    // Bit clock divider
    if (st_ff.clk_run)
    begin
      nxt_st.div_cnt = (st_ff.div_cnt == 16'd0) ? DIV_CYC - 16'd1 : st_ff.div_cnt - 16'd1;
      if (tick)
        nxt_st.fall_cnt = st_ff.fall_cnt + 4'd1;
    end
    // Clock stop request, wake on receive activity
    nxt_st.rx_prev = serial_rx_in_i;
    if (st_ff.ctrl[ASP_CTRL_CLKSTOP])
      nxt_st.clk_run = 1'b0;
    if (serial_rx_in_i != st_ff.rx_prev)
    begin
      nxt_st.clk_run = 1'b1;
      nxt_st.ctrl[ASP_CTRL_CLKSTOP] = 1'b0;
    end
    if (!st_ff.ctrl[ASP_CTRL_CLKSTOP] && !st_ff.clk_run)
      nxt_st.clk_run = 1'b1;
    // Transmitter sequencer
    if (bit_fall && st_ff.ctrl[ASP_CTRL_TXEN])
    begin
      unique case (st_ff.tx_fsm)
        TX_IDLE:
          if (st_ff.tx_full && (cts || !st_ff.ctrl[ASP_CTRL_AUTOCTS]))
          begin
            nxt_st.tx_sh = st_ff.tx_hold;
            nxt_st.tx_full = 1'b0;
            nxt_st.tx_fsm = TX_START;
          end
        TX_START:
        begin
          nxt_st.tx_bit = 3'd0;
          nxt_st.tx_fsm = TX_DATA;
        end
        TX_DATA:
        begin
          nxt_st.tx_sh = {1'b0, st_ff.tx_sh[ASP_DATA_W-1:1]};
          nxt_st.tx_bit = st_ff.tx_bit + 3'd1;
          if (st_ff.tx_bit == 3'd7)
            nxt_st.tx_fsm = TX_STOP;
        end
        TX_STOP:
          nxt_st.tx_fsm = TX_IDLE;
      endcase
    end
    if (!st_ff.ctrl[ASP_CTRL_TXEN])
      nxt_st.tx_fsm = TX_IDLE;
    // Line level: mark unless framing a character
    unique case (nxt_st.tx_fsm)
      TX_START: nxt_st.tx_line = 1'b0;
      TX_DATA: nxt_st.tx_line = nxt_st.tx_sh[0];
      default: nxt_st.tx_line = 1'b1;
    endcase
    if (st_ff.ctrl[ASP_CTRL_LOOP] || !st_ff.ctrl[ASP_CTRL_TXEN])
      nxt_st.tx_line = 1'b1;
    // Request-to-send from queue fill or manual bit
    if (st_ff.ctrl[ASP_CTRL_AUTORTS])
      nxt_st.rts_n = (q_level == 2'd2);
    else
      nxt_st.rts_n = !st_ff.ctrl[ASP_CTRL_RTSMAN];
    // Bus access
    if (req)
    begin
      unique case (wb_adr_i)
        ASP_CTRL_OFF:
        begin
          if (wb_we_i && wb_sel_i[0])
            nxt_st.ctrl = wb_dat_i[ASP_CTRL_W-1:0];
          nxt_st.rdat = {25'd0, st_ff.ctrl};
        end
        ASP_STAT_OFF:
        begin
          nxt_st.rdat[ASP_STAT_TXRDY] = !st_ff.tx_full;
          nxt_st.rdat[ASP_STAT_RXAV] = q_s.valid;
          nxt_st.rdat[ASP_STAT_TXBUSY] = (st_ff.tx_fsm != TX_IDLE);
          nxt_st.rdat[ASP_STAT_CTS] = cts;
          nxt_st.rdat[ASP_STAT_RTS] = !st_ff.rts_n;
          nxt_st.rdat[ASP_STAT_CLKRUN] = st_ff.clk_run;
          nxt_st.rdat[ASP_STAT_FRERR] = st_ff.frerr;
          nxt_st.rdat[ASP_STAT_OVR] = st_ff.ovr;
          if (wb_we_i && wb_sel_i[0])
          begin
            if (wb_dat_i[ASP_STAT_FRERR])
              nxt_st.frerr = 1'b0;
            if (wb_dat_i[ASP_STAT_OVR])
              nxt_st.ovr = 1'b0;
          end
        end
        ASP_TXD_OFF:
          if (wb_we_i && wb_sel_i[0])
          begin
            if (st_ff.tx_full)
              nxt_st.ovr = 1'b1;
            else
            begin
              nxt_st.tx_hold = wb_dat_i[ASP_DATA_W-1:0];
              nxt_st.tx_full = 1'b1;
            end
          end
        ASP_RXD_OFF:
          nxt_st.rdat = {24'd0, rxd_pop};
        default: nxt_st.rdat = '0;
      endcase
    end
    // Hardware sets win over software clears
    if (rx_frerr)
      nxt_st.frerr = 1'b1;
    if (fr_s.valid && !fr_s.ready && rx_frerr)
      nxt_st.ovr = 1'b1;
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_ff <= '{ctrl: ASP_CTRL_RST, clk_run: 1'b1, rx_prev: 1'b1, tx_fsm: TX_IDLE,
                 tx_line: 1'b1, rts_n: 1'b1, default: '0};
    else
      st_ff <= nxt_st;
  end
endmodule : asp_top

// [asp_top_assertions.sv]
// Checker for the serial port pin block
`timescale 1ns/1ps
module asp_top_assertions
  import asp_pkg::*;
#(
  parameter logic [15:0] DIV_CYC = 16'(ASP_DIV_CYC)
)(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic [3:0] wb_adr_i, // Address
  input wire logic [31:0] wb_dat_i, // Wdata
  input wire logic [31:0] wb_dat_o, // Rdata
  input wire logic wb_we_i, // Write
  input wire logic [3:0] wb_sel_i, // Lanes
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_ack_o, // Ack
  input wire logic serial_tx_out_o, // Tx
  input wire logic serial_rx_in_i, // Rx
  input wire logic clear_to_send_in_n_i, // Permit
  input wire logic request_to_send_out_n_o // Ready
);
  localparam int BIT = 16 * DIV_CYC;
  logic prev_ff, rst_ff;
  logic [15:0] run_ff, low_ff;
  // Run lengths of the transmit line, the run since a change saturating
  always_ff @(posedge clk_i)
  begin
    prev_ff <= serial_tx_out_o;
    rst_ff <= rst_i;
    run_ff <= rst_i ? 16'hffff : (serial_tx_out_o != prev_ff) ? 16'h0000 :
      run_ff + 16'(run_ff != 16'hffff);
    low_ff <= (rst_i || serial_tx_out_o) ? 16'h0000 : low_ff + 16'h0001;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (wb_ack_o && $past(wb_adr_i[1:0] != 2'b00) |-> wb_dat_o == 0)
    else $error("unmapped read not zero");
  a_reset_idle: assert property (rst_ff |-> serial_tx_out_o && request_to_send_out_n_o)
    else $error("lines not idle after reset");
  a_tx_bitlen: assert property (serial_tx_out_o != prev_ff |-> run_ff >= BIT - 1)
    else $error("tx bit too short");
  a_tx_lowmax: assert property (low_ff <= 9 * BIT)
    else $error("tx low beyond a frame");
endmodule : asp_top_assertions

// [asp_serial_peer.sv]
// Far-end serial device model
`timescale 1ns/1ps
module asp_serial_peer #(
  parameter int BIT = 32
)(
  input wire logic clk_i, // Clock
  input wire logic serial_tx_out_i, // From port
  output logic serial_rx_in_o, // Into port
  output logic clear_to_send_in_n_o // Send permit
);
  // Line at mark, sending permitted
  initial
  begin
    serial_rx_in_o = 1'b1;
    clear_to_send_in_n_o = 1'b0;
  end
  // Grant or withhold the permit
  task set_cts(input logic v);
    @(posedge clk_i);
    clear_to_send_in_n_o <= v;
  endtask : set_cts
  // Send one frame with chosen stop level
  task send_byte(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk_i);
      serial_rx_in_o <= f[i];
      repeat (BIT - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    serial_rx_in_o <= 1'b1;
  endtask : send_byte
  // Catch one frame, sampled mid-bit
  task recv_byte(output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    d = 8'h00;
    while (serial_tx_out_i !== 1'b0 && n < 4 * BIT)
    begin
      @(negedge clk_i);
      n++;
    end
    repeat (BIT / 2) @(negedge clk_i);
    ok = (n < 4 * BIT) && (serial_tx_out_i === 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(negedge clk_i);
      d[i] = serial_tx_out_i;
    end
    repeat (BIT) @(negedge clk_i);
    ok = ok && (serial_tx_out_i === 1'b1);
  endtask : recv_byte
endmodule : asp_serial_peer

// [asp_top_tb.sv]
// Self-checking bench for the serial port pin block
`timescale 1ns/1ps
module asp_top_tb;
  import asp_pkg::*;
  localparam int BIT = 32;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic we = 1'b0;
  logic [3:0] sel = 4'h1;
  logic stb = 1'b0;
  logic cyc = 1'b0;
  logic [31:0] rdat;
  logic ack, tx, rx, cts_n, rts_n;
  int seed = 32'h6a7e_8434;
  int checks = 0;
  int fail_count = 0;
  always #5 clk = ~clk;
  asp_top #(.DIV_CYC(16'h0002)) asp_top_i (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_stb_i(stb),
    .wb_cyc_i(cyc), .wb_ack_o(ack), .serial_tx_out_o(tx), .serial_rx_in_i(rx),
    .clear_to_send_in_n_i(cts_n), .request_to_send_out_n_o(rts_n));
  asp_serial_peer #(.BIT(BIT)) asp_serial_peer_i (.clk_i(clk), .serial_tx_out_i(tx),
    .serial_rx_in_o(rx), .clear_to_send_in_n_o(cts_n));
  // Queue full holds the remote off
  function logic exp_rts(input int held);
    return held >= ASP_RXQ_DEPTH;
  endfunction : exp_rts
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task end_sim;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  // One classic bus cycle, waits for ack
  task wb(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    {adr, we, wdat, cyc, stb} <= {a, w, d, 2'b11};
    // Hold the request until ack is seen at a rising edge
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (n >= 50)
    begin
      fail_count++;
      end_sim();
    end
  endtask : wb
  // Count cycles off mark
  task idle_check(input string what);
    int n;
    n = 0;
    repeat (4 * BIT) @(negedge clk) n += int'(tx !== 1'b1);
    check(what, 0, n);
  endtask : idle_check
  // Write a byte and catch its frame
  task send(input logic [7:0] d, input logic hold);
    logic [31:0] q;
    logic [7:0] r;
    logic ok;
    wb(ASP_TXD_OFF, 1'b1, {24'h00_0000, d}, q);
    if (hold)
    begin
      idle_check("cts hold");
      asp_serial_peer_i.set_cts(1'b0);
    end
    asp_serial_peer_i.recv_byte(r, ok);
    check("tx byte", 32'(d), 32'(r));
    check("tx frame", 1, 32'(ok));
  endtask : send
  initial
  begin
    logic [31:0] q;
    logic [7:0] sent [2];
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wb(ASP_CTRL_OFF, 1'b0, 0, q);
    check("ctrl", 32'(ASP_CTRL_RST), q);
    check("tx idle", 1, 32'(tx));
    wb(4'h2, 1'b0, 0, q);
    check("unmapped", 0, q);
    $display("reset test done");
    wb(ASP_CTRL_OFF, 1'b1, 32'h0000_0001, q);
    for (int i = 0; i < 3; i++)
      send((i == 0) ? 8'h00 : 8'($random(seed)), 1'b0);
    wb(ASP_CTRL_OFF, 1'b1, 32'h0000_0009, q);
    asp_serial_peer_i.set_cts(1'b1);
    send(8'($random(seed)), 1'b1);
    $display("transmit test done");
    // Fill the queue, then drain it
    wb(ASP_CTRL_OFF, 1'b1, 32'h0000_0012, q);
    for (int i = 0; i < 3; i++)
    begin
      repeat (2) @(negedge clk);
      check("rts", 32'(exp_rts(i)), 32'(rts_n));
      if (i < 2)
      begin
        sent[i] = 8'($random(seed));
        asp_serial_peer_i.send_byte(sent[i], 1'b1);
      end
    end
    for (int i = 0; i < 2; i++)
    begin
      wb(ASP_RXD_OFF, 1'b0, 0, q);
      check("rx byte", 32'(sent[i]), q);
      repeat (2) @(negedge clk);
      check("rts", 32'(exp_rts(1 - i)), 32'(rts_n));
    end
    $display("receive test done");
    wb(ASP_CTRL_OFF, 1'b1, 32'h0000_0042, q);
    wb(ASP_STAT_OFF, 1'b0, 0, q);
    check("clk run", 0, 32'(q[ASP_STAT_CLKRUN]));
    asp_serial_peer_i.send_byte(8'($random(seed)), 1'b1);
    wb(ASP_STAT_OFF, 1'b0, 0, q);
    check("clk run", 1, 32'(q[ASP_STAT_CLKRUN]));
    wb(ASP_CTRL_OFF, 1'b0, 0, q);
    check("ctrl wake", 32'h0000_0002, q);
    $display("wake test done");
    // Low stop bit drops the byte
    repeat (2) wb(ASP_RXD_OFF, 1'b0, 0, q);
    wb(ASP_STAT_OFF, 1'b1, 32'h0000_00c0, q);
    asp_serial_peer_i.send_byte(8'($random(seed)), 1'b0);
    wb(ASP_STAT_OFF, 1'b0, 0, q);
    check("frame err", 1, 32'(q[ASP_STAT_FRERR]));
    wb(ASP_RXD_OFF, 1'b0, 0, q);
    check("rx drop", 0, q);
    $display("frame test done");
    for (int i = 0; i < 2; i++)
    begin
      wb(ASP_CTRL_OFF, 1'b1, (i == 0) ? 32'h0000_0005 : 32'h0000_0000, q);
      wb(ASP_TXD_OFF, 1'b1, 32'(8'($random(seed))), q);
      idle_check("mark");
    end
    $display("mark test done");
    end_sim();
  end
  // Cut a hang short
  initial
  begin
    repeat (100000) @(posedge clk);
    fail_count++;
    end_sim();
  end
endmodule : asp_top_tb
bind asp_top asp_top_assertions #(.DIV_CYC(DIV_CYC)) asp_top_assertions_i (.clk_i(clk_i),
  .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i),
  .wb_ack_o(wb_ack_o), .serial_tx_out_o(serial_tx_out_o), .serial_rx_in_i(serial_rx_in_i),
  .clear_to_send_in_n_i(clear_to_send_in_n_i),
  .request_to_send_out_n_o(request_to_send_out_n_o));
